// ===== tmr_irq_cfg.svh
// constants for the timer and interrupt control block
// assumes inclusion by bare name from presc_div, tmr_irq_ctrl and the bench
`ifndef TMR_IRQ_CFG_SVH
`define TMR_IRQ_CFG_SVH

// ************************************
// register indexes, byte address = 4 * index
// ************************************
`define IDX_CTRL     4'h6
`define IDX_TIMER    4'h7
`define IDX_HOLD_HI  4'h8
`define IDX_HOLD_LO  4'h9

// ************************************
// control port bit positions
// ************************************
`define BIT_EXT_EN   0
`define BIT_TMR_EN   1
`define BIT_ACT_LVL  2
`define BIT_RUN      3
`define BIT_PULSE    4
`define BIT_DIV2     5
`define BIT_DIV5     6
`define BIT_DIV20    7

// ************************************
// reset values and counts
// ************************************
`define CTRL_RST     8'h00
`define TIMER_ONE    8'h01
`define FACT_ONE     16'h0001
`define FACT_DIV2    16'h0002
`define FACT_DIV5    16'h0005
`define FACT_DIV20   16'h0014
`define MC_SHORT     3'h4
`define MC_LONG      3'h6
`define VEC_TIMER    12'h020
`define VEC_EXT      12'h0a0
`define VEC_RST      12'h000

`endif

// ===== tmr_irq_pkg.sv
// types for the timer and interrupt control block
// assumes tmr_irq_cfg.svh holds all numeric constants
`default_nettype none
package tmr_irq_pkg;

    // ************************************
    // timer modes
    // ************************************
    typedef enum logic [1:0] {
        MODE_INTERVAL = 2'b00,
        MODE_PULSE    = 2'b01,
        MODE_EVENT    = 2'b10
    } mode_t;

    // ************************************
    // state records
    // ************************************
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } presc_state_t;

    typedef struct packed {
        logic        wr_d;
        logic [3:0]  idx_d;
        logic [31:0] rdata;
        logic [7:0]  ctrl;
        logic [7:0]  timer;
        logic [7:0]  reload;
        logic [7:0]  hold_hi;
        logic [7:0]  hold_lo;
        logic        sync1;
        logic        sync2;
        logic        act_d;
        logic        tmr_pend;
        logic        ext_pend;
        logic        phi;
        logic [2:0]  mc;
        logic        irq;
        logic [11:0] vec;
    } core_state_t;

endpackage : tmr_irq_pkg
`default_nettype wire

// ===== presc_div.sv
// prescaler: divides the phase-clock enable by a 16-bit value
// assumes div is never zero and phi_en is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
`include "tmr_irq_cfg.svh"
module presc_div
    import tmr_irq_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // control
    input  wire logic        phi_en,
    input  wire logic        clr,
    input  wire logic [15:0] div,
    // count enable out
    output logic             tick
);

    presc_state_t s;
    presc_state_t n;

    // ************************************
    // division
    // ************************************
    always_comb begin
        n = s;
        n.tick = 1'b0;
        if (clr) begin
            n.cnt = '0;
        end else if (phi_en) begin
            // >= guards a divisor lowered while counting
            if (s.cnt >= div - `FACT_ONE) begin
                n.cnt = '0;
                n.tick = 1'b1;
            end else begin
                n.cnt = s.cnt + `FACT_ONE;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;

    // ************************************
    // checks
    // ************************************
    property p_tick_single;
        @(posedge hclk) disable iff (!hresetn)
        s.tick |=> !s.tick;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("prescaler tick longer than one cycle");

endmodule : presc_div
`default_nettype wire

// ===== tmr_irq_ctrl.sv
// timer and interrupt control: 8-bit down timer, prescaler, edge irq
// assumes an ahb-lite master and a core that acks the presented vector
//
// Operation
// - bit 4 clear with any prescale bit set selects interval mode.
// - interval mode with bit 3 set counts down from reload per tick.
// - count after 01 reloads the timer and sets the timer request.
// - reload value 00 gives a 256-count request period.
// - timer request reaches the core only while bit 1 is set.
// - timer request clears only by core ack or a timer write.
// - timer reads return the count without disturbing anything.
// - bit 3 clear holds the count and resets the prescaler.
// - requests pass to the core on 4 or 6 phase machine cycles.
// - bit 4 set with a prescale bit set selects pulse width mode.
// - bit 2 sets edge input active level, one meaning active high.
// - pulse mode counts only while the edge input is active.
// - pulse mode trailing edge stops counting, may set external request.
// - bit 4 and all prescale bits clear select event counter mode.
// - event mode decrements per active edge, no prescaler.
// - interval and event modes latch external request on active edge.
// - external request holds until ack or bit 0 clear.
// - core takes a forwarded request only when its allow flag is set.
// - timer request is serviced before the external one.
// - vectors are 020 for timer and 0a0 for external.
// - core ack after the vector clears the matching request.
// - timer write loads timer and reload, clears prescaler and request.
// - bits 5, 6, 7 select factors 2, 5, 20, multiplied together.
// - all prescale bits and nonzero holding pair divide by that pair.
// - control read gives zeros in bits 0 to 6, pin in bit 7.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_irq_cfg.svh"
module tmr_irq_ctrl
    import tmr_irq_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // edge input pin
    input  wire logic        edge_event_input,
    // processor core side
    input  wire logic        long_cycle,
    input  wire logic        cpu_irq_allow_flag,
    input  wire logic        irq_ack,
    output logic             irq_req,
    output logic             irq_take,
    output logic [11:0]      irq_vector
);

    core_state_t s;
    core_state_t n;

    mode_t       mode;
    logic        aph;
    logic        hit;
    logic        cwr;
    logic        twr;
    logic        act;
    logic        rise;
    logic        fall;
    logic        tick;
    logic        presc_clr;
    logic        step;
    logic        reload_now;
    logic        fwd_t;
    logic        fwd_e;
    logic        bound;
    logic        ack_t;
    logic        ack_e;
    logic        ext_set;
    logic [2:0]  mc_len;
    logic [15:0] fac;
    logic [15:0] div;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ************************************
    // mode and prescaler selection
    // ************************************
    always_comb begin
        if (s.ctrl[`BIT_PULSE]) begin
            mode = MODE_PULSE;
        end else if (|s.ctrl[`BIT_DIV20:`BIT_DIV2]) begin
            mode = MODE_INTERVAL;
        end else begin
            mode = MODE_EVENT;
        end
    end

    always_comb begin
        fac = `FACT_ONE;
        if (s.ctrl[`BIT_DIV2]) begin
            fac = 16'(fac * `FACT_DIV2);
        end
        if (s.ctrl[`BIT_DIV5]) begin
            fac = 16'(fac * `FACT_DIV5);
        end
        if (s.ctrl[`BIT_DIV20]) begin
            fac = 16'(fac * `FACT_DIV20);
        end
    end

    // holding pair only when all three factor bits are set
    assign div = (&s.ctrl[`BIT_DIV20:`BIT_DIV2]) && ({s.hold_hi, s.hold_lo} != '0)
               ? {s.hold_hi, s.hold_lo} : fac;

    // ************************************
    // edge input
    // ************************************
    // sync2 only: sync1 feeds nothing else
    assign act  = ~(s.sync2 ^ s.ctrl[`BIT_ACT_LVL]);
    assign rise = act & ~s.act_d;
    assign fall = ~act & s.act_d;

    // ************************************
    // counting
    // ************************************
    assign aph = hsel & htrans[1] & hready;
    assign hit = (haddr[31:6] == '0) && (haddr[5:2] >= `IDX_CTRL)
              && (haddr[5:2] <= `IDX_HOLD_LO);
    assign cwr = s.wr_d && (s.idx_d == `IDX_CTRL);
    assign twr = s.wr_d && (s.idx_d == `IDX_TIMER);

    always_comb begin
        presc_clr = 1'b1;
        step = 1'b0;
        if (mode == MODE_INTERVAL) begin
            presc_clr = ~s.ctrl[`BIT_RUN] | twr;
            step = s.ctrl[`BIT_RUN] & tick;
        end else if (mode == MODE_PULSE) begin
            presc_clr = ~s.ctrl[`BIT_RUN] | twr | ~act;
            step = s.ctrl[`BIT_RUN] & act & tick;
        end else begin
            step = s.ctrl[`BIT_RUN] & rise;
        end
    end

    presc_div u_presc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .phi_en  (s.phi),
        .clr     (presc_clr),
        .div     (div),
        .tick    (tick)
    );

    assign reload_now = step & (s.timer == `TIMER_ONE) & ~twr;

    // ************************************
    // request handling
    // ************************************
    always_comb begin
        if (mode == MODE_PULSE) begin
            ext_set = s.ctrl[`BIT_EXT_EN] & fall;
        end else begin
            ext_set = s.ctrl[`BIT_EXT_EN] & rise;
        end
    end

    assign fwd_t  = s.tmr_pend & s.ctrl[`BIT_TMR_EN];
    assign fwd_e  = s.ext_pend;
    assign mc_len = long_cycle ? `MC_LONG : `MC_SHORT;
    // a boundary is the last phase period of a machine cycle;
    // >= ends a cycle at once if long_cycle drops mid-way, no wrap
    assign bound  = s.phi && (s.mc >= mc_len - 3'h1);
    assign ack_t  = irq_ack & s.irq & (s.vec == `VEC_TIMER);
    assign ack_e  = irq_ack & s.irq & (s.vec == `VEC_EXT);

    // ************************************
    // next state
    // ************************************
    always_comb begin
        n = s;
        n.phi = ~s.phi;
        n.wr_d = aph & hwrite & hit;
        n.idx_d = haddr[5:2];
        n.sync1 = edge_event_input;
        n.sync2 = s.sync1;
        n.act_d = act;
        if (cwr) begin
            n.ctrl = hwdata[7:0];
        end
        if (s.wr_d && (s.idx_d == `IDX_HOLD_HI)) begin
            n.hold_hi = hwdata[7:0];
        end
        if (s.wr_d && (s.idx_d == `IDX_HOLD_LO)) begin
            n.hold_lo = hwdata[7:0];
        end
        if (twr) begin
            n.timer = hwdata[7:0];
            n.reload = hwdata[7:0];
        end else if (reload_now) begin
            n.timer = s.reload;
        end else if (step) begin
            n.timer = s.timer - `TIMER_ONE;
        end
        // set wins over ack; a timer write clears outright
        if (twr) begin
            n.tmr_pend = 1'b0;
        end else if (reload_now) begin
            n.tmr_pend = 1'b1;
        end else if (ack_t) begin
            n.tmr_pend = 1'b0;
        end
        if (!n.ctrl[`BIT_EXT_EN]) begin
            n.ext_pend = 1'b0;
        end else if (ext_set) begin
            n.ext_pend = 1'b1;
        end else if (ack_e) begin
            n.ext_pend = 1'b0;
        end
        if (s.phi) begin
            n.mc = bound ? 3'h0 : s.mc + 3'h1;
        end
        // requests are raised only at machine-cycle boundaries; an ack drops them at once
        if (irq_ack) begin
            n.irq = 1'b0;
        end else if (bound) begin
            n.irq = fwd_t | fwd_e;
            if (fwd_t) begin
                n.vec = `VEC_TIMER;
            end else if (fwd_e) begin
                n.vec = `VEC_EXT;
            end
        end
        // read data taken from the post-write view, so a read right
        // after a write sees the new value
        if (aph && !hwrite) begin
            if (!hit) begin
                n.rdata = '0;
            end else if (haddr[5:2] == `IDX_CTRL) begin
                n.rdata = {24'h000000, s.sync2, 7'h00};
            end else if (haddr[5:2] == `IDX_TIMER) begin
                n.rdata = {24'h000000, n.timer};
            end else if (haddr[5:2] == `IDX_HOLD_HI) begin
                n.rdata = {24'h000000, n.hold_hi};
            end else begin
                n.rdata = {24'h000000, n.hold_lo};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ************************************
    // outputs
    // ************************************
    // zero wait states; hsize ignored, word access only
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = s.rdata;
    assign irq_req    = s.irq;
    assign irq_vector = s.vec;
    // the core still decides when to take it
    assign irq_take   = s.irq & cpu_irq_allow_flag;

    // ************************************
    // checks
    // ************************************
    property p_reload;
        reload_now |=> (s.timer == $past(s.reload)) && s.tmr_pend;
    endproperty
    a_reload: assert property (p_reload)
        else $error("timer did not reload and set request");

    property p_tmr_clr;
        $fell(s.tmr_pend) |-> $past(ack_t || twr);
    endproperty
    a_tmr_clr: assert property (p_tmr_clr)
        else $error("timer request cleared without cause");

    property p_stop_hold;
        !s.ctrl[`BIT_RUN] && !twr |=> s.timer == $past(s.timer);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stopped timer changed");

    property p_fwd;
        bound && !irq_ack |=> s.irq == $past(fwd_t || fwd_e);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forwarded request wrong at boundary");

    property p_prio;
        bound && !irq_ack && fwd_t |=> s.vec == `VEC_TIMER;
    endproperty
    a_prio: assert property (p_prio)
        else $error("timer request not ranked first");

    property p_pulse_idle;
        mode == MODE_PULSE && !act |-> presc_clr && !step;
    endproperty
    a_pulse_idle: assert property (p_pulse_idle)
        else $error("pulse mode counts while input inactive");

    property p_ext_off;
        !s.ctrl[`BIT_EXT_EN] |-> !s.ext_pend;
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("external request held while disabled");

    property p_twr;
        twr |=> s.timer == $past(hwdata[7:0]) && s.reload == s.timer && !s.tmr_pend;
    endproperty
    a_twr: assert property (p_twr)
        else $error("timer write not applied");

    property p_ctrl_rd;
        aph && !hwrite && hit && haddr[5:2] == `IDX_CTRL |=> s.rdata[6:0] == 7'h00;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("control read low bits not zero");

    property p_evt;
        mode == MODE_EVENT && step && !twr && s.timer != `TIMER_ONE
        |=> s.timer == $past(s.timer) - `TIMER_ONE;
    endproperty
    a_evt: assert property (p_evt)
        else $error("event count step wrong");

    c_reload: cover property (reload_now);
    c_ext: cover property ($rose(s.ext_pend));
    c_tmr_irq: cover property (s.irq && s.vec == `VEC_TIMER ##1 irq_ack);
    c_pulse: cover property (mode == MODE_PULSE && step);

endmodule : tmr_irq_ctrl
`default_nettype wire

// ===== core_seq_model.sv
// core interrupt sequencer model: takes forwarded requests and acks them
// assumes the bench drives the allow flag and the edge pin itself
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // block side
    input  wire logic        irq_req,
    input  wire logic        irq_take,
    input  wire logic [11:0] irq_vector,
    output logic             irq_ack,
    output logic             long_cycle,
    // bench side
    input  wire logic        slow,
    output logic [11:0]      taken_vec,
    output int               n_taken
);
    logic [5:0] lc;
    initial begin
        irq_ack = 1'b0;
        long_cycle = 1'b0;
        taken_vec = 12'h000;
        n_taken = 0;
        lc = 6'h00;
    end
    // both machine cycle lengths occur
    always @(posedge hclk) begin
        lc <= lc + 6'h01;
        long_cycle <= lc[5];
    end
    // ack one cycle, only while still forwarded and allowed
    always begin
        @(posedge hclk);
        #1;
        if (hresetn === 1'b1 && irq_take === 1'b1) begin
            repeat (slow ? 6 : 0) @(posedge hclk);
            @(posedge hclk);
            if (irq_take === 1'b1) begin
                taken_vec <= irq_vector;
                n_taken <= n_taken + 1;
                irq_ack <= 1'b1;
                @(posedge hclk);
                irq_ack <= 1'b0;
                @(posedge hclk);
            end
        end
    end
endmodule : core_seq_model
`default_nettype wire

// ===== timer_and_interrupt_control_tb.sv
// self-checking bench for the timer and interrupt control block
// assumes the core model answers requests; the bench drives bus and pin
`timescale 1ns/1ps
`default_nettype none
`include "tmr_irq_cfg.svh"
module timer_and_interrupt_control_tb;
    import tmr_irq_pkg::*;
    typedef struct {logic [7:0] ctrl; logic [15:0] hold; int fac;} row_t;
    logic        hclk, hresetn, hsel, hwrite, pin, allow, slow;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, held;
    logic        hreadyout, hresp, irq_ack, long_cycle, irq_req, irq_take;
    logic [11:0] irq_vector, taken_vec;
    int          n_taken, n_fail, samples_checked;
    row_t        rows [8] = '{'{8'h28, 16'h0, 2}, '{8'h48, 16'h0, 5}, '{8'h88, 16'h0, 20},
        '{8'h68, 16'h0, 10}, '{8'ha8, 16'h0, 40}, '{8'hc8, 16'h0, 100},
        '{8'he8, 16'h0, 200}, '{8'he8, 16'h0003, 3}};

    tmr_irq_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .edge_event_input(pin), .long_cycle(long_cycle), .cpu_irq_allow_flag(allow),
        .irq_ack(irq_ack), .irq_req(irq_req), .irq_take(irq_take), .irq_vector(irq_vector));
    core_seq_model i_core (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
        .irq_take(irq_take), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .long_cycle(long_cycle), .slow(slow), .taken_vec(taken_vec), .n_taken(n_taken));

    // ************************************
    // tasks
    // ************************************
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {26'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    // a boundary comes within 12 cycles, so 30 covers sync and boundary
    task automatic req_is(input logic exp, input logic [11:0] v, input string what);
        repeat (30) @(posedge hclk);
        @(negedge hclk);
        chk(what, {31'h0, irq_req}, {31'h0, exp});
        if (exp) chk(what, {20'h0, irq_vector}, {20'h0, v});
        @(posedge hclk);
    endtask : req_is
    task automatic pulse(input int n, input logic act);
        repeat (n) begin
            pin <= act;
            repeat (4) @(posedge hclk);
            pin <= ~act;
            repeat (4) @(posedge hclk);
        end
        repeat (6) @(posedge hclk);
    endtask : pulse
    task automatic took(input int k, input logic [11:0] v, input string what);
        for (int t = 0; t < 80 && n_taken < k; t++) @(posedge hclk);
        chk(what, n_taken, k);
        chk(what, {20'h0, taken_vec}, {20'h0, v});
    endtask : took

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // whole run is about 20k cycles
    initial begin
        repeat (60000) @(posedge hclk);
        n_fail++;
        give_verdict();
    end

    // ************************************
    // main sequence
    // ************************************
    initial begin
        {hresetn, hsel, htrans, haddr, hwrite, hwdata, pin, allow, slow} = '0;
        hsize = 3'h2;
        n_fail = 0;
        samples_checked = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `IDX_TIMER, 8'h00, rd);
        chk("timer_rst", rd, 32'h0);
        chk("resp", {30'h0, hresp, hreadyout}, 32'h1);
        pin <= 1'b1;
        repeat (6) @(posedge hclk);
        bus(1'b0, `IDX_CTRL, 8'h00, rd);
        chk("ctrl_pin", rd, 32'h80);
        bus(1'b1, 4'h3, 8'hff, rd);
        bus(1'b0, 4'h3, 8'h00, rd);
        chk("unmapped", rd, 32'h0);
        pin <= 1'b0;
        $display("reset and map done");
        // prescale table, then a stop must freeze the count
        foreach (rows[i]) begin
            bus(1'b1, `IDX_HOLD_HI, rows[i].hold[15:8], rd);
            bus(1'b1, `IDX_HOLD_LO, rows[i].hold[7:0], rd);
            bus(1'b1, `IDX_CTRL, rows[i].ctrl, rd);
            bus(1'b1, `IDX_TIMER, 8'hc8, rd);
            repeat (40 * rows[i].fac) @(posedge hclk);
            bus(1'b0, `IDX_TIMER, 8'h00, rd);
            chk("timer_span", {31'h0, rd inside {[179:181]}}, 32'h1);
            bus(1'b1, `IDX_CTRL, rows[i].ctrl & 8'hf7, rd);
            bus(1'b0, `IDX_TIMER, 8'h00, rd);
            held = rd;
            repeat (4 * rows[i].fac) @(posedge hclk);
            bus(1'b0, `IDX_TIMER, 8'h00, rd);
            chk("timer_held", rd, held);
            $display("row %0d done", i);
        end
        // event mode, masked request, write clears it, 256 period
        bus(1'b1, `IDX_CTRL, 8'h0c, rd);
        bus(1'b1, `IDX_TIMER, 8'h03, rd);
        pulse(3, 1'b1);
        bus(1'b0, `IDX_TIMER, 8'h00, rd);
        chk("ev_reload", rd, 32'h3);
        req_is(1'b0, 12'h0, "masked");
        bus(1'b1, `IDX_CTRL, 8'h0e, rd);
        req_is(1'b1, `VEC_TIMER, "unmasked");
        chk("no_take", {31'h0, irq_take}, 32'h0);
        bus(1'b1, `IDX_TIMER, 8'h00, rd);
        req_is(1'b0, 12'h0, "wr_clear");
        pulse(255, 1'b1);
        req_is(1'b0, 12'h0, "before_256");
        pulse(1, 1'b1);
        req_is(1'b1, `VEC_TIMER, "at_256");
        allow <= 1'b1;
        took(1, `VEC_TIMER, "ack_tmr");
        req_is(1'b0, 12'h0, "ack_clear");
        allow <= 1'b0;
        $display("event mode done");
        // both pending: timer goes first, slow core
        bus(1'b1, `IDX_CTRL, 8'h0f, rd);
        bus(1'b1, `IDX_TIMER, 8'h01, rd);
        pulse(1, 1'b1);
        req_is(1'b1, `VEC_TIMER, "both");
        slow <= 1'b1;
        allow <= 1'b1;
        took(2, `VEC_TIMER, "first");
        took(3, `VEC_EXT, "second");
        allow <= 1'b0;
        slow <= 1'b0;
        $display("priority done");
        // external latch cleared by enable, not latched while off
        bus(1'b1, `IDX_CTRL, 8'h0d, rd);
        bus(1'b1, `IDX_TIMER, 8'h50, rd);
        pulse(1, 1'b1);
        req_is(1'b1, `VEC_EXT, "ext_set");
        bus(1'b1, `IDX_CTRL, 8'h0c, rd);
        req_is(1'b0, 12'h0, "ext_off");
        pulse(1, 1'b1);
        bus(1'b1, `IDX_CTRL, 8'h0d, rd);
        req_is(1'b0, 12'h0, "ext_none");
        // active low: pin idles high before the level flips
        pin <= 1'b1;
        bus(1'b1, `IDX_CTRL, 8'h0c, rd);
        bus(1'b1, `IDX_CTRL, 8'h09, rd);
        req_is(1'b0, 12'h0, "lvl_quiet");
        pulse(1, 1'b0);
        req_is(1'b1, `VEC_EXT, "lvl_low");
        bus(1'b1, `IDX_CTRL, 8'h08, rd);
        pin <= 1'b0;
        $display("external done");
        // pulse width: count only while active, request on trailing edge
        bus(1'b1, `IDX_CTRL, 8'h3d, rd);
        bus(1'b1, `IDX_TIMER, 8'hc8, rd);
        req_is(1'b0, 12'h0, "pw_idle");
        bus(1'b0, `IDX_TIMER, 8'h00, rd);
        chk("pw_idle_t", rd, 32'hc8);
        pin <= 1'b1;
        repeat (40) @(posedge hclk);
        pin <= 1'b0;
        req_is(1'b1, `VEC_EXT, "pw_trail");
        bus(1'b0, `IDX_TIMER, 8'h00, rd);
        chk("pw_width", {31'h0, rd inside {[189:191]}}, 32'h1);
        held = rd;
        repeat (40) @(posedge hclk);
        bus(1'b0, `IDX_TIMER, 8'h00, rd);
        chk("pw_stop", rd, held);
        $display("pulse width done");
        // reset in mid-run with a request standing
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("rst_req", {16'h0, irq_vector, 3'h0, irq_req}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `IDX_TIMER, 8'h00, rd);
        chk("rst_timer", rd, 32'h0);
        $display("mid reset done");
        give_verdict();
    end
endmodule : timer_and_interrupt_control_tb
`default_nettype wire
